// ===== err_rec_consts.svh
// offsets, field positions, codes and reset values of the error record block
`ifndef ERR_REC_CONSTS_SVH
`define ERR_REC_CONSTS_SVH

// ==================================================
// address map, one 64-byte window per record
`define REG_ADDR_W 12
`define REC_STRIDE_LOG2 6
`define OFF_FEATURE 6'h00
`define OFF_CONTROL 6'h08
`define OFF_MISC 6'h20

// ==================================================
// control register bit positions (combined name / split read name first)
`define CTL_ED 0
`define CTL_IMPL 1
`define CTL_UI 2
`define CTL_FI 3
`define CTL_UE 4
`define CTL_WUI 5
`define CTL_WFI 6
`define CTL_WUE 7
`define CTL_CFI 8
`define CTL_WRITE_CORRECTED_FAULT_EN 9
`define CTL_DUI 10
`define CTL_WRITE_DEFERRED_IRQ_EN 11
`define CTL_IMPL_BITS 12

// ==================================================
// feature register field positions
`define FR_ED_LSB 0
`define FR_IMPL_LSB 2
`define FR_UI_LSB 4
`define FR_FI_LSB 6
`define FR_UE_LSB 8
`define FR_CFI_LSB 10
`define FR_CEC_LSB 12
`define FR_RP_BIT 15
`define FR_DUI_LSB 16
`define FR_CEO_LSB 18
`define FR_HI_LSB 32

// ==================================================
// feature codes
`define MODE_NONE 2'b00
`define MODE_ALWAYS 2'b01
`define MODE_ONE 2'b10
`define MODE_SPLIT 2'b11
`define CEC_NONE 3'b000
`define CEC_8BIT 3'b010
`define CEC_16BIT 3'b100
`define CEO_KEEP 2'b00
`define CEO_OVERWRITE 2'b01

// ==================================================
// miscellaneous register layout and reset values
`define MISC_CNT_LSB 32
`define ED_RESET_VAL 1'b0

`endif

// ===== err_rec_pkg.sv
// types shared by the error record block
`include "err_rec_consts.svh"
package err_rec_pkg;

  // ==================================================
  // error class of a detected error
  typedef enum logic [2:0] {
    ERR_CE = 3'b001,
    ERR_DE = 3'b010,
    ERR_UE = 3'b100
  } err_kind_e;

  // ==================================================
  // one detected error from the node datapath
  typedef struct packed {
    logic valid;
    err_kind_e kind;
    logic is_write;
    logic prio_held;
    logic [31:0] syndrome;
  } err_event_s;

  // ==================================================
  // one register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`REG_ADDR_W-1:0] addr;
    logic [63:0] wdata;
  } reg_req_s;

endpackage : err_rec_pkg

// ===== ce_counter.sv
// corrected-error counter with sticky overflow
`timescale 1ns/1ps
module ce_counter #(
  parameter int CNT_BITS = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inc,
  input wire logic wr_en,
  input wire logic [CNT_BITS-1:0] wr_cnt,
  input wire logic wr_of,
  output logic [CNT_BITS-1:0] count,
  output logic ovf,
  output logic wrap
);

  logic [CNT_BITS-1:0] count_reg;
  logic [CNT_BITS-1:0] count_next;
  logic ovf_reg;

  // ==================================================
  // count: software write wins so a persistent error cannot block a reset
  assign count_next = count_reg + {{(CNT_BITS-1){1'b0}}, 1'b1};
  assign wrap = inc & (&count_reg); // increment through zero

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (wr_en) begin
      count_reg <= wr_cnt;
    end else if (inc) begin
      count_reg <= count_next;
    end
  end

  // sticky overflow: the hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_reg <= 1'b0;
    end else if (wrap) begin
      ovf_reg <= 1'b1; // see R24
    end else if (wr_en) begin
      ovf_reg <= wr_of;
    end
  end

  assign count = count_reg;
  assign ovf = ovf_reg;

  // ==================================================
  // checks
  wrap_sets_ovf_a: assert property (@(posedge clk) disable iff (rst) // see R24
    // a same-cycle software write loads the count, but the wrap still sets the flag
    wrap |=> ovf && (count == ($past(wr_en) ? $past(wr_cnt) : '0)))
    else $error("overflow not set after counter wrap");

endmodule : ce_counter

// ===== error_record_control_features.sv
// control, feature and miscellaneous registers of one node's error record
// How it works
// R01: uncorrected errors raise recovery interrupt when enabled
// R02: interrupt raised even when syndrome is dropped
// R03: split mode: bit 2 gates reads only
// R04: bit 1 implementation value, zero writes harmless
// R05: reporting off: record and signal nothing
// R06: reporting off may still correct silently
// R07: check codes still generated unless injection suppresses
// R08: reporting enable resets to zero
// R09: unsupported control bits read zero, ignore writes
// R10: feature register only in first record
// R11: feature high word implementation, 31:20 zero
// R12: repeat corrected error policy, overflow flag
// R13: overwrite policy zero without counter
// R14: deferred interrupt control code, zero without recovery
// R15: repeat counter bit, zero without counter
// R16: standard counter kind and width
// R17: corrected fault control code, zero without fault
// R18: in-band abort reporting code
// R19: fault interrupt code
// R20: recovery interrupt code, bits 3:2 implementation
// R21: reporting enable code
// R22: latest-error syndrome ignores writes while valid
// R23: deferred errors raise recovery interrupt when enabled
// R24: counter wrap sets overflow, raises fault interrupt
// R25: records replicated at 64-byte stride; only record 0 here, other windows read zero, ignore writes
// R26: interrupts are levels held until record cleared
`timescale 1ns/1ps
`include "err_rec_consts.svh"
module error_record_control_features #(
  parameter logic [1:0] ED_MODE = `MODE_ONE,
  parameter logic [1:0] UI_MODE = `MODE_SPLIT,
  parameter logic [1:0] FI_MODE = `MODE_ONE,
  parameter logic [1:0] UE_MODE = `MODE_ONE,
  parameter logic [1:0] CFI_MODE = `MODE_ONE,
  parameter logic [1:0] DUI_MODE = `MODE_ONE,
  parameter logic [2:0] CEC_KIND = `CEC_16BIT,
  parameter logic RP_PRESENT = 1'b0,
  parameter logic [1:0] CEO_POLICY = `CEO_KEEP,
  parameter logic [31:0] IMPL_FR_HI = 32'h0000_0000, // arbitrary
  parameter logic [1:0] IMPL_FR_LO = 2'b00, // arbitrary
  parameter logic [31:0] IMPL_CTL_HI = 32'h0000_0000, // arbitrary
  parameter logic IMPL_CTL_BIT1 = 1'b0 // arbitrary
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire err_rec_pkg::reg_req_s REG_REQ,
  output logic [63:0] REG_RDATA,
  output logic REG_RVALID,
  input wire err_rec_pkg::err_event_s ERR_EVT,
  input wire logic RECORD_CLEAR,
  input wire logic INJECT_SUPPRESS,
  output logic RECOVERY_IRQ,
  output logic FAULT_IRQ,
  output logic ABORT_RESP,
  output logic DETECT_EN,
  output logic CHECK_GEN_EN,
  output logic MISC_VALID,
  output logic STATUS_OVF
);
  import err_rec_pkg::*;

  localparam int CNT_BITS = (CEC_KIND == `CEC_8BIT) ? 7 : 15;
  localparam logic HAS_CNT = (CEC_KIND != `CEC_NONE);

  // ==================================================
  // helpers
  // writable control bits for one feature code
  function automatic logic [11:0] ctl_bits(input logic [1:0] mode, input int rb, input int wb);
    logic [11:0] m;
    m = '0;
    if (mode == `MODE_ONE || mode == `MODE_SPLIT) begin
      m[rb] = 1'b1;
    end
    if (mode == `MODE_SPLIT) begin
      m[wb] = 1'b1;
    end
    return m;
  endfunction : ctl_bits

  // effective enable for one access direction
  function automatic logic ctl_en(input logic [1:0] mode, input logic [11:0] ctl,
                                  input int rb, input int wb, input logic is_wr);
    logic e;
    e = 1'b0;
    case (mode)
      `MODE_ALWAYS: e = 1'b1;
      `MODE_ONE: e = ctl[rb];
      `MODE_SPLIT: e = is_wr ? ctl[wb] : ctl[rb];
      default: e = 1'b0;
    endcase
    return e;
  endfunction : ctl_en

  // feature word, with dependent fields forced to zero
  function automatic logic [63:0] feature_word();
    logic [63:0] f;
    f = '0;
    f[`FR_HI_LSB +: 32] = IMPL_FR_HI; // see R11
    f[`FR_ED_LSB +: 2] = ED_MODE; // see R21
    f[`FR_IMPL_LSB +: 2] = IMPL_FR_LO; // see R20
    f[`FR_UI_LSB +: 2] = UI_MODE; // see R20
    f[`FR_FI_LSB +: 2] = FI_MODE; // see R19
    f[`FR_UE_LSB +: 2] = UE_MODE; // see R18
    f[`FR_CFI_LSB +: 2] = (FI_MODE == `MODE_NONE) ? 2'b00 : CFI_MODE; // see R17
    f[`FR_CEC_LSB +: 3] = CEC_KIND; // see R16
    f[`FR_RP_BIT] = HAS_CNT & RP_PRESENT; // see R15
    f[`FR_DUI_LSB +: 2] = (UI_MODE == `MODE_NONE) ? 2'b00 : DUI_MODE; // see R14
    f[`FR_CEO_LSB +: 2] = HAS_CNT ? CEO_POLICY : 2'b00; // see R12 see R13
    return f;
  endfunction : feature_word

  localparam logic [63:0] FEATURE = feature_word();
  // bits without a supported feature stay zero; bit 1 is never stored
  localparam logic [11:0] CTL_MASK = ctl_bits(ED_MODE, `CTL_ED, `CTL_ED)
    | ctl_bits(UI_MODE, `CTL_UI, `CTL_WUI) | ctl_bits(FI_MODE, `CTL_FI, `CTL_WFI)
    | ctl_bits(UE_MODE, `CTL_UE, `CTL_WUE)
    | ctl_bits(FEATURE[`FR_CFI_LSB +: 2], `CTL_CFI, `CTL_WRITE_CORRECTED_FAULT_EN)
    | ctl_bits(FEATURE[`FR_DUI_LSB +: 2], `CTL_DUI, `CTL_WRITE_DEFERRED_IRQ_EN);

  // ==================================================
  // address decode
  logic rec0;
  logic [5:0] off;
  logic ctl_wr;
  logic misc_wr;
  assign off = REG_REQ.addr[`REC_STRIDE_LOG2-1:0];
  assign rec0 = (REG_REQ.addr[`REG_ADDR_W-1:`REC_STRIDE_LOG2] == '0); // see R25
  assign ctl_wr = REG_REQ.wr & rec0 & (off == `OFF_CONTROL);
  assign misc_wr = REG_REQ.wr & rec0 & (off == `OFF_MISC) & ~REG_REQ.rd;

  // ==================================================
  // control register
  logic [11:0] ctl_reg;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctl_reg <= {11'h000, `ED_RESET_VAL} & CTL_MASK; // see R08
    end else if (ctl_wr) begin
      ctl_reg <= REG_REQ.wdata[11:0] & CTL_MASK; // see R09 see R04
    end
  end

  logic ed_on;
  assign ed_on = (ED_MODE == `MODE_ALWAYS) | ((ED_MODE == `MODE_ONE) & ctl_reg[`CTL_ED]);

  // ==================================================
  // event qualification: nothing is recorded or signalled with reporting off
  logic act;
  logic is_ce;
  logic is_de;
  logic is_ue;
  logic wr_dir;
  logic ui_en;
  logic dui_en;
  logic fi_en;
  logic cf_en;
  logic ue_en;
  assign act = ERR_EVT.valid & ed_on; // see R05
  assign is_ce = (ERR_EVT.kind == ERR_CE);
  assign is_de = (ERR_EVT.kind == ERR_DE);
  assign is_ue = (ERR_EVT.kind == ERR_UE);
  assign wr_dir = ERR_EVT.is_write;
  assign ui_en = ctl_en(UI_MODE, ctl_reg, `CTL_UI, `CTL_WUI, wr_dir); // see R03
  assign dui_en = ctl_en(FEATURE[`FR_DUI_LSB +: 2], ctl_reg, `CTL_DUI, `CTL_WRITE_DEFERRED_IRQ_EN, wr_dir);
  assign fi_en = ctl_en(FI_MODE, ctl_reg, `CTL_FI, `CTL_WFI, wr_dir);
  assign ue_en = ctl_en(UE_MODE, ctl_reg, `CTL_UE, `CTL_WUE, wr_dir);
  // without a corrected-fault control the fault enable covers corrected errors
  assign cf_en = (FEATURE[`FR_CFI_LSB +: 2] == `MODE_NONE) ? fi_en
    : ctl_en(FEATURE[`FR_CFI_LSB +: 2], ctl_reg, `CTL_CFI, `CTL_WRITE_CORRECTED_FAULT_EN, wr_dir);

  // ==================================================
  // corrected-error counter in the miscellaneous register
  logic [CNT_BITS-1:0] cnt;
  logic cnt_ovf;
  logic cnt_wrap;
  ce_counter #(
    .CNT_BITS(CNT_BITS)
  ) u_counter (
    .clk(CLK_SYS),
    .rst(RST),
    .inc(act & is_ce & HAS_CNT),
    .wr_en(misc_wr & HAS_CNT), // see R22
    .wr_cnt(REG_REQ.wdata[`MISC_CNT_LSB +: CNT_BITS]),
    .wr_of(REG_REQ.wdata[`MISC_CNT_LSB + CNT_BITS]),
    .count(cnt),
    .ovf(cnt_ovf),
    .wrap(cnt_wrap)
  );

  // ==================================================
  // record state: valid flag, held class, overflow flag
  logic mv_reg;
  logic held_ce_reg;
  logic status_of_reg;
  logic [31:0] syn_reg;
  logic repeat_ce;
  logic record_new;
  logic of_set;
  assign repeat_ce = mv_reg & held_ce_reg & is_ce;
  // a repeat corrected error only replaces the syndrome under the overwrite policy
  assign record_new = act & ~ERR_EVT.prio_held & (~repeat_ce
    | (HAS_CNT & (CEO_POLICY == `CEO_OVERWRITE) & ~status_of_reg)); // see R12
  assign of_set = act & repeat_ce & (cnt_wrap | (~HAS_CNT & (CEO_POLICY == `CEO_KEEP)));

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mv_reg <= 1'b0;
      held_ce_reg <= 1'b0;
    end else if (record_new) begin
      mv_reg <= 1'b1;
      held_ce_reg <= is_ce;
    end else if (RECORD_CLEAR) begin
      mv_reg <= 1'b0;
      held_ce_reg <= 1'b0;
    end
  end

  // overflow flag: set wins over clear
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      status_of_reg <= 1'b0;
    end else if (of_set) begin
      status_of_reg <= 1'b1; // see R12
    end else if (RECORD_CLEAR) begin
      status_of_reg <= 1'b0;
    end
  end

  // latest-error syndrome ignores software writes while the record is valid
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      syn_reg <= '0;
    end else if (record_new) begin
      syn_reg <= ERR_EVT.syndrome;
    end else if (misc_wr & ~mv_reg) begin
      syn_reg <= REG_REQ.wdata[31:0]; // see R22
    end
  end

  // ==================================================
  // interrupt levels, held until the record is cleared
  logic rec_irq_set;
  logic fault_set;
  logic rec_irq_reg;
  logic fault_irq_reg;
  // raised even when the syndrome itself is dropped
  assign rec_irq_set = act & ui_en & (is_ue | (is_de & dui_en)); // see R01 see R02 see R23
  assign fault_set = act & (((is_ue | is_de) & fi_en)
    | (is_ce & cf_en & (HAS_CNT ? cnt_wrap : 1'b1))); // see R24

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rec_irq_reg <= 1'b0;
    end else if (rec_irq_set) begin
      rec_irq_reg <= 1'b1; // see R26
    end else if (RECORD_CLEAR) begin
      rec_irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      fault_irq_reg <= 1'b0;
    end else if (fault_set) begin
      fault_irq_reg <= 1'b1; // see R26
    end else if (RECORD_CLEAR) begin
      fault_irq_reg <= 1'b0;
    end
  end

  // ==================================================
  // datapath controls: abort pulse, check-code generation
  // correction may keep running while reporting is off; only logging, interrupts and the abort pulse stop
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ABORT_RESP <= 1'b0;
      CHECK_GEN_EN <= 1'b1;
    end else begin
      ABORT_RESP <= act & is_ue & ue_en;
      CHECK_GEN_EN <= ~INJECT_SUPPRESS; // see R07 see R06
    end
  end

  // ==================================================
  // read data, registered one cycle after the request
  logic [63:0] misc_word;
  always_comb begin
    misc_word = '0;
    misc_word[31:0] = syn_reg;
    if (HAS_CNT) begin
      misc_word[`MISC_CNT_LSB +: CNT_BITS] = cnt;
      misc_word[`MISC_CNT_LSB + CNT_BITS] = cnt_ovf;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      REG_RDATA <= '0;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      if (~REG_REQ.rd | ~rec0) begin
        REG_RDATA <= '0; // see R10
      end else if (off == `OFF_FEATURE) begin
        REG_RDATA <= FEATURE;
      end else if (off == `OFF_CONTROL) begin
        REG_RDATA <= {IMPL_CTL_HI, 20'h00000, ctl_reg[11:2], IMPL_CTL_BIT1, ctl_reg[0]};
      end else if (off == `OFF_MISC) begin
        REG_RDATA <= misc_word;
      end else begin
        REG_RDATA <= '0;
      end
    end
  end

  assign RECOVERY_IRQ = rec_irq_reg;
  assign FAULT_IRQ = fault_irq_reg;
  assign DETECT_EN = ed_on;
  assign MISC_VALID = mv_reg;
  assign STATUS_OVF = status_of_reg;

  // ==================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence feature_rd_s;
    REG_REQ.rd && rec0 && (off == `OFF_FEATURE);
  endsequence

  sequence ue_read_s;
    act && is_ue && !wr_dir;
  endsequence

  ue_raises_irq_a: assert property (act && is_ue && ui_en |=> RECOVERY_IRQ) // see R01
    else $error("recovery interrupt missing for uncorrected error");
  irq_has_cause_a: assert property ($rose(RECOVERY_IRQ) |-> $past(rec_irq_set)) // see R01
    else $error("recovery interrupt raised without cause");
  dropped_still_irq_a: assert property (act && is_ue && ui_en && ERR_EVT.prio_held // see R02
    |=> RECOVERY_IRQ && (syn_reg == $past(syn_reg)))
    else $error("dropped syndrome changed record or lost interrupt");
  split_read_gate_a: assert property ((UI_MODE == `MODE_SPLIT) and ue_read_s // see R03
    and (!ctl_reg[`CTL_UI] && !RECOVERY_IRQ) |=> !RECOVERY_IRQ)
    else $error("read error raised interrupt with read enable clear");
  off_silent_a: assert property (ERR_EVT.valid && !ed_on // see R05
    |=> !$rose(RECOVERY_IRQ) && !$rose(FAULT_IRQ) && !$rose(MISC_VALID))
    else $error("error recorded or signalled with reporting off");
  ctl_unsup_zero_a: assert property ((ctl_reg & ~CTL_MASK) == 12'h000) // see R09
    else $error("unsupported control bit stored");
  other_rec_zero_a: assert property (REG_REQ.rd && !rec0 |=> REG_RVALID && REG_RDATA == '0) // see R10
    else $error("record beyond the first reads nonzero");
  feature_fixed_a: assert property (feature_rd_s // see R11
    |=> REG_RDATA[31:20] == 12'h000 && REG_RDATA[63:32] == IMPL_FR_HI)
    else $error("feature register fields wrong");
  syn_locked_a: assert property (misc_wr && mv_reg && !record_new |=> $stable(syn_reg)) // see R22
    else $error("syndrome written while record valid");
  irq_level_a: assert property (RECOVERY_IRQ && !RECORD_CLEAR |=> RECOVERY_IRQ [*1]) // see R26
    else $error("recovery interrupt dropped before clear");
  wrap_fault_a: assert property (act && is_ce && cf_en && cnt_wrap |=> FAULT_IRQ && STATUS_OVF == // see R24
    $past(mv_reg && held_ce_reg || status_of_reg && !RECORD_CLEAR))
    else $error("counter wrap did not raise fault interrupt");

endmodule : error_record_control_features

// ===== error_record_control_features_tb.sv
// self-checking bench for the error record control and feature registers
`timescale 1ns/1ps
`include "err_rec_consts.svh"

// ==================================================
// one compare, counted; four-state equality so an unknown never matches
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("FAIL t=%0t got %h expected %h", $time, (got), (exp)); \
  end \
end

module error_record_control_features_tb;
  import err_rec_pkg::*;

  // expected feature word for the default parameter set
  localparam logic [63:0] FEAT_EXP = (64'(`MODE_ONE) << `FR_ED_LSB)
    | (64'(`MODE_SPLIT) << `FR_UI_LSB) | (64'(`MODE_ONE) << `FR_FI_LSB)
    | (64'(`MODE_ONE) << `FR_UE_LSB) | (64'(`MODE_ONE) << `FR_CFI_LSB)
    | (64'(`CEC_16BIT) << `FR_CEC_LSB) | (64'(`MODE_ONE) << `FR_DUI_LSB);

  logic CLK_SYS;
  logic RST;
  reg_req_s REG_REQ;
  logic [63:0] REG_RDATA;
  logic REG_RVALID;
  err_event_s ERR_EVT;
  logic RECORD_CLEAR;
  logic INJECT_SUPPRESS;
  logic RECOVERY_IRQ;
  logic FAULT_IRQ;
  logic ABORT_RESP;
  logic DETECT_EN;
  logic CHECK_GEN_EN;
  logic MISC_VALID;
  logic STATUS_OVF;
  int err_total = 0;
  int total_checks = 0;

  error_record_control_features i_dut (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID),
    .ERR_EVT(ERR_EVT),
    .RECORD_CLEAR(RECORD_CLEAR),
    .INJECT_SUPPRESS(INJECT_SUPPRESS),
    .RECOVERY_IRQ(RECOVERY_IRQ),
    .FAULT_IRQ(FAULT_IRQ),
    .ABORT_RESP(ABORT_RESP),
    .DETECT_EN(DETECT_EN),
    .CHECK_GEN_EN(CHECK_GEN_EN),
    .MISC_VALID(MISC_VALID),
    .STATUS_OVF(STATUS_OVF)
  );

  // ==================================================
  // clock, 5 ns period
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end

  // ==================================================
  // bus and event tasks; every request lasts exactly one edge
  task automatic reg_write(input logic [11:0] a, input logic [63:0] d);
    @(posedge CLK_SYS);
    REG_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge CLK_SYS);
    REG_REQ <= '0;
    // let the register settle before any caller looks at decoded outputs
    @(negedge CLK_SYS);
  endtask : reg_write

  // read data is registered, so it is looked at mid-cycle after the taking edge
  task automatic rd_chk(input logic [11:0] a, input logic [63:0] exp);
    @(posedge CLK_SYS);
    REG_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 64'h0};
    @(posedge CLK_SYS);
    REG_REQ <= '0;
    @(negedge CLK_SYS);
    `CHK(REG_RVALID, 1'b1)
    `CHK(REG_RDATA, exp)
  endtask : rd_chk

  task automatic err_event(input err_kind_e k, input logic w, input logic p,
                           input logic [31:0] s);
    @(posedge CLK_SYS);
    ERR_EVT <= '{valid: 1'b1, kind: k, is_write: w, prio_held: p, syndrome: s};
    @(posedge CLK_SYS);
    ERR_EVT <= '0;
    @(negedge CLK_SYS);
  endtask : err_event

  task automatic rec_clear();
    @(posedge CLK_SYS);
    RECORD_CLEAR <= 1'b1;
    @(posedge CLK_SYS);
    RECORD_CLEAR <= 1'b0;
    @(negedge CLK_SYS);
  endtask : rec_clear

  task automatic print_verdict();
    $display("checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // ==================================================
  // watchdog; the whole sequence needs about a hundred cycles
  initial begin
    repeat (5000) @(posedge CLK_SYS);
    err_total++;
    print_verdict();
  end

  // ==================================================
  // main sequence
  initial begin
    RST = 1'b1;
    REG_REQ = '0;
    ERR_EVT = '0;
    RECORD_CLEAR = 1'b0;
    INJECT_SUPPRESS = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(negedge CLK_SYS);
    `CHK(DETECT_EN, 1'b0)
    `CHK(CHECK_GEN_EN, 1'b1)
    rd_chk(12'h008, 64'h0);
    // feature word only in record 0, read-only, high half zero
    rd_chk(12'h000, FEAT_EXP);
    reg_write(12'h000, 64'hffff_ffff_ffff_ffff);
    rd_chk(12'h000, FEAT_EXP);
    rd_chk(12'h040, 64'h0);
    rd_chk(12'h048, 64'h0);
    rd_chk(12'h010, 64'h0);
    // unsupported and implementation bits hold zero when all ones are written
    reg_write(12'h008, 64'hffff_ffff_ffff_ffff);
    rd_chk(12'h008, 64'h0000_0000_0000_053d);
    // reporting off: nothing recorded or signalled, check codes still made
    reg_write(12'h008, 64'h0000_0000_0000_053c);
    err_event(ERR_UE, 1'b0, 1'b0, 32'h0000_0a0a);
    `CHK({DETECT_EN, RECOVERY_IRQ, FAULT_IRQ, MISC_VALID}, 4'h0)
    `CHK(CHECK_GEN_EN, 1'b1)
    // split recovery enable: read enable ignores write errors
    reg_write(12'h008, 64'h0000_0000_0000_0005);
    `CHK(DETECT_EN, 1'b1)
    err_event(ERR_UE, 1'b1, 1'b0, 32'h0000_1234);
    `CHK({RECOVERY_IRQ, MISC_VALID}, 2'b01)
    err_event(ERR_UE, 1'b0, 1'b0, 32'h0000_5678);
    `CHK(RECOVERY_IRQ, 1'b1)
    repeat (5) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    `CHK(RECOVERY_IRQ, 1'b1)
    rec_clear();
    `CHK({RECOVERY_IRQ, MISC_VALID}, 2'b00)
    reg_write(12'h008, 64'h0000_0000_0000_0021);
    err_event(ERR_UE, 1'b1, 1'b0, 32'h0);
    `CHK(RECOVERY_IRQ, 1'b1)
    rec_clear();
    // enable off gives no interrupt; then a dropped syndrome still raises it
    reg_write(12'h008, 64'h0000_0000_0000_0001);
    err_event(ERR_UE, 1'b0, 1'b0, 32'h0000_00aa);
    `CHK({RECOVERY_IRQ, MISC_VALID}, 2'b01)
    reg_write(12'h008, 64'h0000_0000_0000_0005);
    err_event(ERR_UE, 1'b0, 1'b1, 32'h0000_00bb);
    `CHK(RECOVERY_IRQ, 1'b1)
    rd_chk(12'h020, 64'h0000_0000_0000_00aa);
    // latest-error syndrome ignores writes while the record is valid
    reg_write(12'h020, 64'h0000_0000_0000_00cc);
    rd_chk(12'h020, 64'h0000_0000_0000_00aa);
    rec_clear();
    // deferred errors need both the recovery and the deferred enable
    reg_write(12'h008, 64'h0000_0000_0000_0405);
    err_event(ERR_DE, 1'b0, 1'b0, 32'h0);
    `CHK(RECOVERY_IRQ, 1'b1)
    rec_clear();
    reg_write(12'h008, 64'h0000_0000_0000_0005);
    err_event(ERR_DE, 1'b0, 1'b0, 32'h0);
    `CHK(RECOVERY_IRQ, 1'b0)
    rec_clear();
    // abort response is a single-cycle pulse; fault enable covers uncorrected
    reg_write(12'h008, 64'h0000_0000_0000_0019);
    err_event(ERR_UE, 1'b0, 1'b0, 32'h0);
    `CHK({ABORT_RESP, FAULT_IRQ, RECOVERY_IRQ}, 3'b110)
    @(negedge CLK_SYS);
    `CHK(ABORT_RESP, 1'b0)
    rec_clear();
    // corrected errors: count, keep syndrome, wrap sets both overflow flags
    reg_write(12'h008, 64'h0000_0000_0000_0101);
    err_event(ERR_CE, 1'b0, 1'b0, 32'h0000_1111);
    `CHK({FAULT_IRQ, STATUS_OVF, MISC_VALID}, 3'b001)
    rd_chk(12'h020, 64'h0000_0001_0000_1111);
    reg_write(12'h020, 64'h0000_7fff_0000_abcd);
    rd_chk(12'h020, 64'h0000_7fff_0000_1111);
    err_event(ERR_CE, 1'b0, 1'b0, 32'h0000_2222);
    `CHK({FAULT_IRQ, STATUS_OVF}, 2'b11)
    rd_chk(12'h020, 64'h0000_8000_0000_1111);
    rec_clear();
    `CHK({FAULT_IRQ, STATUS_OVF, MISC_VALID}, 3'b000)
    // injection suppress follows one cycle late
    @(posedge CLK_SYS);
    INJECT_SUPPRESS <= 1'b1;
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    `CHK(CHECK_GEN_EN, 1'b0)
    @(posedge CLK_SYS);
    INJECT_SUPPRESS <= 1'b0;
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    `CHK(CHECK_GEN_EN, 1'b1)
    print_verdict();
  end

endmodule : error_record_control_features_tb
